// *** secondary_config_register_bank.sv ***
/*
 * secondary side configuration register bank: arbiter priority and
 * enables, line size, latency limit, header kind, the csr and upstream
 * window base with its setup and translated base, and the window decode.
 * assumes an axi4-lite master on aclk, a setup loader (eeprom, smbus or
 * local processor) on aclk, and direction and bus mode straps as pins.
 */
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "bank_defines.svh"

module secondary_config_register_bank (
    input wire logic aclk,
    input wire logic aresetn,
    input wire bank_pkg::axil_req_t axil_req,
    output bank_pkg::axil_rsp_t axil_rsp,
    input wire logic setup_load_valid,
    input wire logic [31:0] setup_load_data,
    input wire logic reverse_pin,
    input wire logic pcix_pin,
    input wire bank_pkg::dec_req_t dec_req,
    output bank_pkg::dec_rsp_t dec_rsp,
    output bank_pkg::cfg_t cfg
);
    import bank_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic aw_full;
        logic [31:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [31:0] arb;
        logic [7:0] line;
        logic [7:0] lat;
        logic [19:0] base;
        logic [31:0] xlat;
        logic [31:0] setup;
        logic rev_s1;
        logic rev_s2;
        logic pcix_s1;
        logic pcix_s2;
        logic [1:0] settle;
        logic lat_loaded;
        logic dec_valid;
        logic dec_csr;
        logic dec_up;
        logic [31:0] dec_addr;
    } state_t;

    state_t s_q;
    state_t s_d;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] strb,
        input logic [31:0] wmask
    );
        logic [31:0] be;
        be = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge = (old_v & ~(be & wmask)) | (new_v & be & wmask);
    endfunction

    function automatic logic mapped(input logic [31:0] a);
        mapped = (a[31:8] == 24'h000000) && (a[1:0] == 2'b00) &&
            (a[7:0] == `OFS_ARB_PRIO || a[7:0] == `OFS_LINE_LAT ||
             a[7:0] == `OFS_WIN_BASE || a[7:0] == `OFS_XLAT_BASE ||
             a[7:0] == `OFS_WIN_SETUP);
    endfunction

    // ************************************************************
    // read view of each register
    // ************************************************************
    logic [31:0] arb_view;
    logic [31:0] line_lat_view;
    logic [31:0] base_view;
    logic [19:0] win_mask;

    always_comb begin
        arb_view = s_q.arb & `ARB_WMASK;
        line_lat_view = {`HDR_VALUE,
            s_q.rev_s2 ? 8'h00 : s_q.lat,
            s_q.line & `LINE_WMASK};
        base_view = {s_q.base, 8'h00, s_q.setup[3], s_q.setup[2:1],
            1'b0};
        win_mask = s_q.setup[31:12];
    end

    // ************************************************************
    // bus handshakes
    // ************************************************************
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic do_write;

    always_comb begin
        axil_rsp.awready = !s_q.aw_full && !s_q.bvalid;
        axil_rsp.wready = !s_q.w_full && !s_q.bvalid;
        axil_rsp.bvalid = s_q.bvalid;
        axil_rsp.bresp = s_q.bresp;
        axil_rsp.arready = !s_q.rvalid;
        axil_rsp.rvalid = s_q.rvalid;
        axil_rsp.rdata = s_q.rdata;
        axil_rsp.rresp = s_q.rresp;
        aw_take = axil_req.awvalid && axil_rsp.awready;
        w_take = axil_req.wvalid && axil_rsp.wready;
        ar_take = axil_req.arvalid && axil_rsp.arready;
        // commit one cycle after both halves are held
        do_write = s_q.aw_full && s_q.w_full;
    end

    // ************************************************************
    // write decode
    // ************************************************************
    // one strobe per register, none for an unmapped address
    logic wr_hit;
    logic wr_arb;
    logic wr_line;
    logic wr_base;
    logic wr_xlat;
    logic wr_setup;

    always_comb begin
        wr_hit = do_write && mapped(s_q.aw_addr);
        wr_arb = 1'b0;
        wr_line = 1'b0;
        wr_base = 1'b0;
        wr_xlat = 1'b0;
        wr_setup = 1'b0;
        if (!wr_hit) begin
            wr_arb = 1'b0;
        end else if (s_q.aw_addr[7:0] == `OFS_ARB_PRIO) begin
            wr_arb = 1'b1;
        end else if (s_q.aw_addr[7:0] == `OFS_LINE_LAT) begin
            wr_line = 1'b1;
        end else if (s_q.aw_addr[7:0] == `OFS_WIN_BASE) begin
            wr_base = 1'b1;
        end else if (s_q.aw_addr[7:0] == `OFS_XLAT_BASE) begin
            wr_xlat = 1'b1;
        end else if (s_q.aw_addr[7:0] == `OFS_WIN_SETUP) begin
            wr_setup = 1'b1;
        end
    end

    // ************************************************************
    // read decode
    // ************************************************************
    // unmapped or unaligned reads answer zero with an error
    logic rd_hit;
    logic [31:0] rd_word;

    always_comb begin
        rd_hit = mapped(axil_req.araddr);
        rd_word = 32'h0000_0000;
        if (!rd_hit) begin
            rd_word = 32'h0000_0000;
        end else if (axil_req.araddr[7:0] == `OFS_ARB_PRIO) begin
            rd_word = arb_view;
        end else if (axil_req.araddr[7:0] == `OFS_LINE_LAT) begin
            rd_word = line_lat_view;
        end else if (axil_req.araddr[7:0] == `OFS_WIN_BASE) begin
            rd_word = base_view;
        end else if (axil_req.araddr[7:0] == `OFS_XLAT_BASE) begin
            rd_word = s_q.xlat;
        end else if (axil_req.araddr[7:0] == `OFS_WIN_SETUP) begin
            rd_word = s_q.setup;
        end
    end

    // ************************************************************
    // window match
    // ************************************************************
    // the window opens only once setup bit 31 is set
    logic win_hit;
    logic [31:0] win_off;

    always_comb begin
        win_off = dec_req.addr & ~{win_mask, 12'h000};
        win_hit = dec_req.valid && win_mask[19] &&
            ((dec_req.addr[31:12] & win_mask) == (s_q.base & win_mask));
    end

    // ************************************************************
    // next state
    // ************************************************************
    logic [31:0] line_word;
    logic [31:0] lat_word;
    logic [31:0] base_word;

    always_comb begin
        s_d = s_q;
        line_word = 32'h0000_0000;
        lat_word = 32'h0000_0000;
        base_word = 32'h0000_0000;

        // straps cross in through two flops each
        s_d.rev_s1 = reverse_pin;
        s_d.rev_s2 = s_q.rev_s1;
        s_d.pcix_s1 = pcix_pin;
        s_d.pcix_s2 = s_q.pcix_s1;

        // write address and data, either order
        if (aw_take) begin
            s_d.aw_full = 1'b1;
            s_d.aw_addr = axil_req.awaddr;
        end
        if (w_take) begin
            s_d.w_full = 1'b1;
            s_d.w_data = axil_req.wdata;
            s_d.w_strb = axil_req.wstrb;
        end

        if (do_write) begin
            s_d.aw_full = 1'b0;
            s_d.w_full = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            if (wr_hit) begin
                if (wr_arb) begin
                    s_d.arb = merge(s_q.arb, s_q.w_data, s_q.w_strb,
                        `ARB_WMASK);
                end else if (wr_line) begin
                    // only the four size bits of the line byte take data, and the latency byte unless reversed
                    line_word = merge({24'h0, s_q.line}, s_q.w_data,
                        s_q.w_strb, {24'h0, `LINE_WMASK});
                    s_d.line = line_word[7:0];
                    lat_word = merge({16'h0, s_q.lat, 8'h0}, s_q.w_data,
                        s_q.w_strb,
                        s_q.rev_s2 ? 32'h0000_0000 : 32'h0000_ff00);
                    s_d.lat = lat_word[15:8];
                end else if (wr_base) begin
                    base_word = merge({s_q.base, 12'h000}, s_q.w_data,
                        s_q.w_strb, {win_mask, 12'h000});
                    s_d.base = base_word[31:12];
                end else if (wr_xlat) begin
                    s_d.xlat = merge(s_q.xlat, s_q.w_data, s_q.w_strb,
                        32'hffff_f000);
                end else if (wr_setup) begin
                    s_d.setup = merge(s_q.setup, s_q.w_data, s_q.w_strb,
                        32'hffff_f00e);
                end
            end
        end
        if (s_q.bvalid && axil_req.bready) begin
            s_d.bvalid = 1'b0;
        end

        // serial loader wins over a bus write in the same cycle
        if (setup_load_valid) begin
            s_d.setup = setup_load_data & 32'hffff_f00e;
        end

        // reads answer one cycle after the address is taken
        if (ar_take) begin
            // answer stands until rready is seen
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_word;
            s_d.rresp = rd_hit ? `RESP_OKAY
                : `RESP_SLVERR;
        end else if (s_q.rvalid && axil_req.rready) begin
            s_d.rvalid = 1'b0;
        end

        // latency reset value waits for the straps to settle
        if (!s_q.lat_loaded) begin
            if (s_q.settle == `STRAP_SETTLE) begin
                s_d.lat_loaded = 1'b1;
                s_d.lat = (!s_q.rev_s2 && s_q.pcix_s2) ? `LAT_PCIX
                    : `LAT_PCI;
            end else begin
                s_d.settle = s_q.settle + 2'd1;
            end
        end
        // reverse direction keeps the field at zero
        if (s_q.rev_s2) begin
            s_d.lat = 8'h00;
        end

        // window decode, bit 31 of setup opens it
        s_d.dec_valid = dec_req.valid;
        s_d.dec_csr = 1'b0;
        s_d.dec_up = 1'b0;
        s_d.dec_addr = 32'h0000_0000;
        if (win_hit) begin
            if (win_off[31:12] == 20'h00000) begin
                // own registers in the lowest 4KB
                s_d.dec_csr = 1'b1;
                s_d.dec_addr = {20'h00000, win_off[11:0]};
            end else begin
                s_d.dec_up = 1'b1;
                s_d.dec_addr = (s_q.xlat & {win_mask, 12'h000}) | win_off;
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.arb <= `ARB_RESET;
            s_q.base <= `WIN_BASE_RESET;
            s_q.setup <= `SETUP_RESET;
            s_q.xlat <= `XLAT_RESET;
            s_q.bresp <= `RESP_OKAY;
            s_q.rresp <= `RESP_OKAY;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    always_comb begin
        cfg.arb_enable = s_q.arb[8:0];
        cfg.arb_high_prio = s_q.arb[30:22];
        cfg.line_size = s_q.line & `LINE_WMASK;
        cfg.latency = s_q.rev_s2 ? 8'h00 : s_q.lat;
        dec_rsp.valid = s_q.dec_valid;
        dec_rsp.hit_csr = s_q.dec_csr;
        dec_rsp.hit_upstream = s_q.dec_up;
        dec_rsp.addr = s_q.dec_addr;
    end

endmodule // secondary_config_register_bank

// *** bank_defines.svh ***
/*
 * offsets, field layouts, reset values and timing counts of the
 * secondary configuration register bank.
 * assumes byte addresses on a 32-bit register bus.
 */
`ifndef BANK_DEFINES_SVH
`define BANK_DEFINES_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_ARB_PRIO 8'h48
`define OFS_LINE_LAT 8'h4c
`define OFS_WIN_BASE 8'h50
`define OFS_XLAT_BASE 8'he0
`define OFS_WIN_SETUP 8'he4

// ****************************************************************
// reset values and writable bit masks
// ****************************************************************
`define ARB_RESET 32'h0040_01ff
`define ARB_WMASK 32'h7fc0_01ff
`define LINE_WMASK 8'h3c
`define LAT_PCI 8'h00
`define LAT_PCIX 8'h40
`define HDR_VALUE 16'h0000
`define WIN_BASE_RESET 20'h00000
`define SETUP_RESET 32'h0000_0000
`define XLAT_RESET 32'h0000_0000

// ****************************************************************
// answers and timing counts
// ****************************************************************
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define STRAP_SETTLE 2'd3

`endif

// *** bank_pkg.sv ***
/*
 * types of the secondary configuration register bank.
 * assumes bank_defines.svh is on the include path.
 */
package bank_pkg;

    // ************************************************************
    // bus carriers
    // ************************************************************
    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_t;

    // ************************************************************
    // window decode and configuration carriers
    // ************************************************************
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } dec_req_t;

    typedef struct packed {
        logic valid;
        logic hit_csr;
        logic hit_upstream;
        logic [31:0] addr;
    } dec_rsp_t;

    typedef struct packed {
        logic [8:0] arb_enable;
        logic [8:0] arb_high_prio;
        logic [7:0] line_size;
        logic [7:0] latency;
    } cfg_t;

endpackage

// *** bank_properties.sv ***
/*
 * port checker for the secondary configuration register bank.
 * assumes one aclk domain; attached by bind at the foot.
 */
`timescale 1ns/1ps
module bank_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire bank_pkg::axil_req_t axil_req,
    input wire bank_pkg::axil_rsp_t axil_rsp,
    input wire logic setup_load_valid,
    input wire logic [31:0] setup_load_data,
    input wire logic reverse_pin,
    input wire logic pcix_pin,
    input wire bank_pkg::dec_req_t dec_req,
    input wire bank_pkg::dec_rsp_t dec_rsp,
    input wire bank_pkg::cfg_t cfg
);
    import bank_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ****
    // register outputs
    // ****
    property p_prio_reset;
        $rose(aresetn) |-> cfg.arb_high_prio == 9'h001;
    endproperty
    a_prio_reset: assert property (p_prio_reset)
        else $error("priority not at reset value");
    property p_prio_by_write;
        $changed(cfg.arb_high_prio) |-> $rose(axil_rsp.bvalid);
    endproperty
    a_prio_by_write: assert property (p_prio_by_write)
        else $error("priority moved without a write");
    property p_enable_by_write;
        $changed(cfg.arb_enable) |-> $rose(axil_rsp.bvalid);
    endproperty
    a_enable_by_write: assert property (p_enable_by_write)
        else $error("enables moved without a write");
    property p_line_low;
        cfg.line_size[1:0] == 2'b00;
    endproperty
    a_line_low: assert property (p_line_low)
        else $error("line size low bits set");
    property p_line_top;
        cfg.line_size[7:6] == 2'b00;
    endproperty
    a_line_top: assert property (p_line_top)
        else $error("line size top bits set");
    property p_line_by_write;
        $changed(cfg.line_size) |-> $rose(axil_rsp.bvalid);
    endproperty
    a_line_by_write: assert property (p_line_by_write)
        else $error("line size moved without a write");
    // strap passes two sync flops, so allow four samples
    property p_reverse_lat;
        reverse_pin [*4] |=> cfg.latency == 8'h00;
    endproperty
    a_reverse_lat: assert property (p_reverse_lat)
        else $error("latency not zero in reverse");
    // ****
    // window decode
    // ****
    property p_dec_answer;
        dec_req.valid |=> dec_rsp.valid;
    endproperty
    a_dec_answer: assert property (p_dec_answer)
        else $error("decode answer missing");
    property p_csr_offset;
        dec_rsp.hit_csr |-> dec_rsp.valid && dec_rsp.addr[31:12] == 20'h0;
    endproperty
    a_csr_offset: assert property (p_csr_offset)
        else $error("csr hit beyond low page");
    property p_hit_excl;
        !(dec_rsp.hit_csr && dec_rsp.hit_upstream);
    endproperty
    a_hit_excl: assert property (p_hit_excl)
        else $error("both hits at once");
endmodule // bank_properties

bind secondary_config_register_bank bank_properties chk_u (
    .aclk(aclk), .aresetn(aresetn), .axil_req(axil_req),
    .axil_rsp(axil_rsp), .setup_load_valid(setup_load_valid),
    .setup_load_data(setup_load_data), .reverse_pin(reverse_pin),
    .pcix_pin(pcix_pin), .dec_req(dec_req), .dec_rsp(dec_rsp), .cfg(cfg)
);

// *** secondary_config_register_bank_bench.sv ***
/*
 * self-checking bench for the secondary configuration register bank.
 * assumes bank_pkg compiled first; bench is the only bus master.
 */
`timescale 1ns/1ps
module secondary_config_register_bank_bench;
    import bank_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    axil_req_t axil_req = '0;
    axil_rsp_t axil_rsp;
    logic setup_load_valid = 1'b0;
    logic [31:0] setup_load_data = 32'h0;
    logic reverse_pin = 1'b0;
    logic pcix_pin = 1'b0;
    dec_req_t dec_req = '0;
    dec_rsp_t dec_rsp;
    cfg_t cfg;
    int n_errors = 0;
    int checked = 0;
    logic [33:0] rd_q[$];
    logic [1:0] wr_q[$];
    logic [33:0] dec_q[$];
    logic [31:0] d;
    logic [31:0] arb_m;

    always #20 aclk = ~aclk;

    secondary_config_register_bank dut_u (
        .aclk(aclk), .aresetn(aresetn), .axil_req(axil_req),
        .axil_rsp(axil_rsp), .setup_load_valid(setup_load_valid),
        .setup_load_data(setup_load_data), .reverse_pin(reverse_pin),
        .pcix_pin(pcix_pin), .dec_req(dec_req), .dec_rsp(dec_rsp), .cfg(cfg)
    );

    // ****
    // tasks
    // ****
    task check(input logic [33:0] seen, input logic [33:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task complete_run;
        if (n_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task do_reset;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        // latency strap value settles four edges after release
        repeat (4) @(posedge aclk);
    endtask

    task wr(input logic [31:0] a, input logic [31:0] v,
            input logic [3:0] s, input logic [1:0] r);
        logic aw, w, b;
        b = 1'b0;
        wr_q.push_back(r);
        @(posedge aclk);
        axil_req.awvalid <= 1'b1;
        axil_req.awaddr <= a;
        axil_req.wvalid <= 1'b1;
        axil_req.wdata <= v;
        axil_req.wstrb <= s;
        axil_req.bready <= 1'b1;
        while (!b) begin
            @(negedge aclk);
            aw = axil_req.awvalid & axil_rsp.awready;
            w = axil_req.wvalid & axil_rsp.wready;
            b = axil_rsp.bvalid;
            @(posedge aclk);
            if (aw) axil_req.awvalid <= 1'b0;
            if (w) axil_req.wvalid <= 1'b0;
            if (b) axil_req.bready <= 1'b0;
        end
    endtask

    task rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r);
        logic ar, rv;
        rv = 1'b0;
        rd_q.push_back({e, r});
        @(posedge aclk);
        axil_req.arvalid <= 1'b1;
        axil_req.araddr <= a;
        axil_req.rready <= 1'b1;
        while (!rv) begin
            @(negedge aclk);
            ar = axil_req.arvalid & axil_rsp.arready;
            rv = axil_rsp.rvalid;
            @(posedge aclk);
            if (ar) axil_req.arvalid <= 1'b0;
            if (rv) axil_req.rready <= 1'b0;
        end
    endtask

    task dec(input logic [31:0] a, input logic [33:0] e);
        @(posedge aclk);
        dec_req <= {1'b1, a};
        dec_q.push_back(e);
    endtask

    // ****
    // result watcher
    // ****
    always @(negedge aclk) begin
        if (axil_rsp.rvalid === 1'b1 && axil_req.rready === 1'b1)
            check({axil_rsp.rdata, axil_rsp.rresp}, rd_q.pop_front());
        if (axil_rsp.bvalid === 1'b1 && axil_req.bready === 1'b1)
            check(axil_rsp.bresp, wr_q.pop_front());
        if (dec_rsp.valid === 1'b1)
            check({dec_rsp.hit_csr, dec_rsp.hit_upstream,
                (dec_rsp.hit_csr | dec_rsp.hit_upstream) ? dec_rsp.addr
                : 32'h0}, dec_q.pop_front());
    end

    initial begin
        #100000;
        n_errors++;
        complete_run;
    end

    // ****
    // scenarios
    // ****
    initial begin
        void'($urandom(21020));
        do_reset;
        rd(32'h48, 32'h0040_01ff, 2'b00);
        rd(32'h4c, 32'h0, 2'b00);
        rd(32'h50, 32'h0, 2'b00);
        arb_m = 32'h0040_01ff;
        for (int i = 0; i < 4; i++) begin
            d = $urandom;
            arb_m = d & 32'h7fc0_01ff;
            wr(32'h48, d, 4'hf, 2'b00);
            rd(32'h48, arb_m, 2'b00);
            check({cfg.arb_high_prio, cfg.arb_enable},
                {arb_m[30:22], arb_m[8:0]});
        end
        // byte lane zero only clears enables 7:0
        wr(32'h48, 32'h0, 4'h1, 2'b00);
        rd(32'h48, arb_m & 32'hffff_ff00, 2'b00);
        d = $urandom;
        wr(32'h4c, d, 4'hf, 2'b00);
        rd(32'h4c, d & 32'h0000_ff3c, 2'b00);
        check(cfg.line_size, d[7:0] & 8'h3c);
        reverse_pin <= 1'b1;
        repeat (6) @(posedge aclk);
        wr(32'h4c, 32'hffff_ffff, 4'hf, 2'b00);
        rd(32'h4c, 32'h0000_003c, 2'b00);
        check(cfg.latency, 8'h00);
        reverse_pin <= 1'b0;
        pcix_pin <= 1'b1;
        do_reset;
        rd(32'h4c, 32'h0000_4000, 2'b00);
        rd(32'h48, 32'h0040_01ff, 2'b00);
        wr(32'h60, 32'hffff_ffff, 4'hf, 2'b10);
        rd(32'h60, 32'h0, 2'b10);
        wr(32'h50, 32'hffff_ffff, 4'hf, 2'b00);
        rd(32'h50, 32'h0, 2'b00);
        @(posedge aclk);
        setup_load_valid <= 1'b1;
        setup_load_data <= 32'hfff0_000a;
        @(posedge aclk);
        setup_load_valid <= 1'b0;
        rd(32'h50, 32'h0000_000a, 2'b00);
        wr(32'h50, 32'hffff_ffff, 4'hf, 2'b00);
        rd(32'h50, 32'hfff0_000a, 2'b00);
        wr(32'he0, 32'h1234_5678, 4'hf, 2'b00);
        rd(32'he0, 32'h1234_5000, 2'b00);
        dec(32'hfff0_0010, {2'b10, 32'h0000_0010});
        dec(32'hfff0_5004, {2'b01, 32'h1230_5004});
        dec(32'h1000_0000, 34'h0);
        @(posedge aclk);
        dec_req.valid <= 1'b0;
        repeat (4) @(posedge aclk);
        check(rd_q.size() + wr_q.size() + dec_q.size(), 34'h0);
        complete_run;
    end
endmodule // secondary_config_register_bank_bench
